// [adcsr_map.svh]
// named constants of the converter serial read-out link
// assumes a 250 MHz core clock; all times held in picoseconds
`ifndef ADCSR_MAP_SVH
`define ADCSR_MAP_SVH
`define ADCSR_BITS 16
`define ADCSR_CHAIN_DEVS 2
`define ADCSR_CLK_PS 4000
`define ADCSR_CEIL(ps) (((ps) + `ADCSR_CLK_PS - 1) / `ADCSR_CLK_PS)
`define ADCSR_FLOOR(ps) ((ps) / `ADCSR_CLK_PS)
`define ADCSR_TCONV_MAX_PS 8800000
`define ADCSR_TWH_CNV_PS 10000
`define ADCSR_TWL_CNV_PS 20000
`define ADCSR_TSU_DI_PS 7500
`define ADCSR_TSCLK_PS 64000
`define ADCSR_CONV_CYC `ADCSR_FLOOR(`ADCSR_TCONV_MAX_PS)
`define ADCSR_SU_CYC `ADCSR_CEIL(`ADCSR_TSU_DI_PS)
`define ADCSR_QUIET_CYC `ADCSR_CEIL(`ADCSR_TWL_CNV_PS)
`define ADCSR_WH_CYC `ADCSR_CEIL(`ADCSR_TWH_CNV_PS)
`define ADCSR_HALF_CYC `ADCSR_CEIL(`ADCSR_TSCLK_PS / 2)
`define ADCSR_SAMPLE_AT (`ADCSR_HALF_CYC / 2)
`define ADCSR_SYNC_SLACK 8
`define ADCSR_CNT_W 12
`endif

// [adcsr_pkg.sv]
// types shared by both ends of the converter serial read-out link
// assumes adcsr_map.svh for all figures
package adcsr_pkg;
  typedef enum logic [1:0] {
    ADCSR_M3W = 2'b00,
    ADCSR_M4W = 2'b01,
    ADCSR_MCHAIN = 2'b10
  } adcsr_mode_t;
  typedef enum logic [1:0] {
    DS_ACQ = 2'b00,
    DS_CONV = 2'b01,
    DS_WAIT = 2'b10,
    DS_SHIFT = 2'b11
  } adcsr_dstate_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SETUP = 3'b001,
    HS_CONV = 3'b010,
    HS_SELECT = 3'b011,
    HS_CLK = 3'b100,
    HS_QUIET = 3'b101
  } adcsr_hstate_t;
endpackage

// [adcsr_if.sv]
// link wires between host and converter
// the serial output is modelled with a pull-up while released
`timescale 1ns/1ns
interface adcsr_if;
  logic convStrobe;
  logic sclk;
  logic din;
  logic dout;
  logic doutOeN;
  logic doutWire;
  assign doutWire = doutOeN ? 1'b1 : dout;
  modport dev (input convStrobe, input sclk, input din, output dout, output doutOeN);
  modport host (output convStrobe, output sclk, output din, input doutWire);
endinterface

// [adcsr_dev.sv]
// converter end: conversion timing, mode choice and serial result shifter
// assumes all link pins arrive asynchronous to core_clk and the host
// keeps the link timing it is bound to
`timescale 1ns/1ns
`include "adcsr_map.svh"

// Summary of operation
// (R1) host holds strobe high at least 10 ns
// (R2) next bit driven on each shift-clock fall
// (R3) 3-wire: strobe low after conversion drives MSB
// (R4) 3-wire: release on strobe high or frame end
// (R5) 4-wire: serial input low drives MSB
// (R6) 4-wire: release on input high or frame end
// (R7) host keeps input high 10 ns between frames
// (R8) host keeps strobe low 20 ns between starts
// (R9) input high at strobe rise selects select-mode
// (R10) input low at strobe rise selects chain
// (R11) chain: capture input on each clock fall
// (R12) host keeps shift clock stable at strobe rise
// (R13) mode chosen per conversion from input level
// (R14) low power after conversion through acquisition
// (R15) strobe acts as chip select in 3-wire
// (R16) result sent MSB first, one bit per clock
// (R17) chain: upstream bits follow own result
// (R18) host waits longest conversion before reading
module adcsr_dev
  import adcsr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // converter core
  input wire logic [`ADCSR_BITS-1:0] sampleData,
  output logic lowPower,
  output logic chainMode,
  // serial link
  adcsr_if.dev link
);

  // pin synchronisers and edge history
  logic strobeS1_r;
  logic strobeS2_r;
  logic strobePrev_r;
  logic sclkS1_r;
  logic sclkS2_r;
  logic sclkPrev_r;
  logic dinS1_r;
  logic dinS2_r;

  logic strobeRise;
  logic sclkFall;

  // control state
  adcsr_dstate_t state_r;
  adcsr_dstate_t state_nxt;
  logic [`ADCSR_CNT_W-1:0] cnt_r;
  logic [`ADCSR_CNT_W-1:0] cnt_nxt;
  logic [`ADCSR_BITS-1:0] shift_r;
  logic [`ADCSR_BITS-1:0] shift_nxt;
  logic [4:0] bitCnt_r;
  logic [4:0] bitCnt_nxt;
  logic chain_r;
  logic chain_nxt;
  logic selByDin_r;
  logic selByDin_nxt;
  logic dout_r;
  logic dout_nxt;
  logic oeN_r;
  logic oeN_nxt;
  logic lowPower_r;
  logic lowPower_nxt;

  // the first flop of each pin is read only by the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobeS1_r <= 1'b0;
      strobeS2_r <= 1'b0;
      strobePrev_r <= 1'b0;
      sclkS1_r <= 1'b0;
      sclkS2_r <= 1'b0;
      sclkPrev_r <= 1'b0;
      dinS1_r <= 1'b1;
      dinS2_r <= 1'b1;
    end else if (clkEn) begin
      strobeS1_r <= link.convStrobe;
      strobeS2_r <= strobeS1_r;
      strobePrev_r <= strobeS2_r;
      sclkS1_r <= link.sclk;
      sclkS2_r <= sclkS1_r;
      sclkPrev_r <= sclkS2_r;
      dinS1_r <= link.din;
      dinS2_r <= dinS1_r;
    end
  end

  assign strobeRise = strobeS2_r & ~strobePrev_r;
  assign sclkFall = ~sclkS2_r & sclkPrev_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    bitCnt_nxt = bitCnt_r;
    chain_nxt = chain_r;
    selByDin_nxt = selByDin_r;
    dout_nxt = dout_r;
    oeN_nxt = oeN_r;
    lowPower_nxt = lowPower_r;
    // strobe edges are ignored while a conversion runs
    if (strobeRise && state_r != DS_CONV) begin
      // (R13) per-conversion mode latch
      // (R9) (R10) input level picks mode
      chain_nxt = ~dinS2_r;
      // (R4) strobe high releases output
      oeN_nxt = 1'b1;
      lowPower_nxt = 1'b0;
      bitCnt_nxt = 5'h00;
      cnt_nxt = `ADCSR_CNT_W'(`ADCSR_CONV_CYC - 1);
      state_nxt = DS_CONV;
    end else begin
      unique case (state_r)
        DS_ACQ: begin
        end
        DS_CONV: begin
          if (cnt_r == `ADCSR_CNT_W'(0)) begin
            // (R14) power down at conversion end
            lowPower_nxt = 1'b1;
            shift_nxt = sampleData;
            state_nxt = DS_WAIT;
          end else begin
            cnt_nxt = cnt_r - `ADCSR_CNT_W'(1);
          end
        end
        DS_WAIT: begin
          if (!strobeS2_r) begin
            // (R3) (R15) strobe low selects, MSB out
            oeN_nxt = 1'b0;
            dout_nxt = shift_r[`ADCSR_BITS-1];
            selByDin_nxt = 1'b0;
            state_nxt = DS_SHIFT;
          end else if (!chain_r && !dinS2_r) begin
            // (R5) input low selects, MSB out
            oeN_nxt = 1'b0;
            dout_nxt = shift_r[`ADCSR_BITS-1];
            selByDin_nxt = 1'b1;
            state_nxt = DS_SHIFT;
          end
        end
        DS_SHIFT: begin
          if (selByDin_r && !chain_r && dinS2_r) begin
            // (R6) input high releases output
            oeN_nxt = 1'b1;
            state_nxt = DS_ACQ;
          end else if (sclkFall) begin
            // (R2) (R16) next bit on falling edge
            // (R11) (R17) upstream bit enters at bottom
            shift_nxt = {shift_r[`ADCSR_BITS-2:0], dinS2_r};
            dout_nxt = shift_r[`ADCSR_BITS-2];
            bitCnt_nxt = bitCnt_r + 5'h01;
            // (R4) (R6) release after last fall
            if (!chain_r && bitCnt_r == 5'(`ADCSR_BITS - 1)) begin
              oeN_nxt = 1'b1;
              state_nxt = DS_ACQ;
            end
          end
        end
      endcase
    end
  end

  // chain frames have no length limit; only the next strobe rise ends them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= DS_ACQ;
      cnt_r <= `ADCSR_CNT_W'(0);
      shift_r <= `ADCSR_BITS'(0);
      bitCnt_r <= 5'h00;
      chain_r <= 1'b0;
      selByDin_r <= 1'b0;
      dout_r <= 1'b0;
      oeN_r <= 1'b1;
      lowPower_r <= 1'b1;
    end else if (clkEn) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      bitCnt_r <= bitCnt_nxt;
      chain_r <= chain_nxt;
      selByDin_r <= selByDin_nxt;
      dout_r <= dout_nxt;
      oeN_r <= oeN_nxt;
      lowPower_r <= lowPower_nxt;
    end
  end

  assign link.dout = dout_r;
  assign link.doutOeN = oeN_r;
  assign lowPower = lowPower_r;
  assign chainMode = chain_r;

endmodule

// [adcsr_host.sv]
// host end: starts conversions, makes the shift clock, gathers results
// assumes the converter answers within the longest conversion time
`timescale 1ns/1ns
`include "adcsr_map.svh"

module adcsr_host
  import adcsr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // user requests
  input wire logic start,
  input wire adcsr_mode_t mode,
  output logic busy,
  output logic [`ADCSR_BITS*`ADCSR_CHAIN_DEVS-1:0] rdData,
  output logic rdValid,
  // serial link
  adcsr_if.host link
);

  localparam int unsigned TotW = `ADCSR_BITS * `ADCSR_CHAIN_DEVS;

  logic doutS1_r;
  logic doutS2_r;
  adcsr_hstate_t state_r;
  adcsr_hstate_t state_nxt;
  adcsr_mode_t mode_r;
  adcsr_mode_t mode_nxt;
  logic [`ADCSR_CNT_W-1:0] cnt_r;
  logic [`ADCSR_CNT_W-1:0] cnt_nxt;
  logic [5:0] bitCnt_r;
  logic [5:0] bitCnt_nxt;
  logic [5:0] lastBit;
  logic [TotW-1:0] data_r;
  logic [TotW-1:0] data_nxt;
  logic [TotW-1:0] rdData_r;
  logic [TotW-1:0] rdData_nxt;
  logic sclk_r;
  logic sclk_nxt;
  logic strobe_r;
  logic strobe_nxt;
  logic din_r;
  logic din_nxt;
  logic valid_r;
  logic valid_nxt;
  logic busy_r;
  logic busy_nxt;
  logic cntDone;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doutS1_r <= 1'b1;
      doutS2_r <= 1'b1;
    end else if (clkEn) begin
      doutS1_r <= link.doutWire;
      doutS2_r <= doutS1_r;
    end
  end

  assign cntDone = (cnt_r == `ADCSR_CNT_W'(0));
  assign lastBit = (mode_r == ADCSR_MCHAIN) ? 6'(TotW - 1) : 6'(`ADCSR_BITS - 1);

  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    cnt_nxt = cntDone ? cnt_r : cnt_r - `ADCSR_CNT_W'(1);
    bitCnt_nxt = bitCnt_r;
    data_nxt = data_r;
    rdData_nxt = rdData_r;
    sclk_nxt = sclk_r;
    strobe_nxt = strobe_r;
    din_nxt = din_r;
    valid_nxt = 1'b0;
    busy_nxt = busy_r;
    unique case (state_r)
      HS_IDLE: begin
        if (start) begin
          mode_nxt = mode;
          // (R9) (R10) input level set ahead of strobe rise
          din_nxt = (mode != ADCSR_MCHAIN);
          data_nxt = TotW'(0);
          bitCnt_nxt = 6'h00;
          busy_nxt = 1'b1;
          cnt_nxt = `ADCSR_CNT_W'(`ADCSR_SU_CYC - 1);
          state_nxt = HS_SETUP;
        end
      end
      HS_SETUP: begin
        if (cntDone) begin
          // (R1) (R12) strobe high well past 10 ns, clock held low
          strobe_nxt = 1'b1;
          cnt_nxt = `ADCSR_CNT_W'(`ADCSR_CONV_CYC + `ADCSR_SYNC_SLACK - 1);
          state_nxt = HS_CONV;
        end
      end
      HS_CONV: begin
        // (R18) wait out the longest conversion
        if (cntDone) begin
          if (mode_r == ADCSR_M4W) begin
            din_nxt = 1'b0;
          end else begin
            strobe_nxt = 1'b0;
          end
          cnt_nxt = `ADCSR_CNT_W'(`ADCSR_HALF_CYC - 1);
          state_nxt = HS_SELECT;
        end
      end
      HS_SELECT: begin
        if (cntDone) begin
          sclk_nxt = 1'b1;
          cnt_nxt = `ADCSR_CNT_W'(`ADCSR_HALF_CYC - 1);
          state_nxt = HS_CLK;
        end
      end
      HS_CLK: begin
        // sample halfway through the high phase to cover both synchroniser delays
        if (sclk_r && cnt_r == `ADCSR_CNT_W'(`ADCSR_SAMPLE_AT)) begin
          data_nxt = {data_r[TotW-2:0], doutS2_r};
        end
        if (cntDone) begin
          sclk_nxt = ~sclk_r;
          cnt_nxt = `ADCSR_CNT_W'(`ADCSR_HALF_CYC - 1);
          if (sclk_r) begin
            bitCnt_nxt = bitCnt_r + 6'h01;
            if (bitCnt_r == lastBit) begin
              // (R7) deselect first, strobe follows
              din_nxt = 1'b1;
              cnt_nxt = `ADCSR_CNT_W'(`ADCSR_QUIET_CYC + `ADCSR_WH_CYC - 1);
              state_nxt = HS_QUIET;
            end
          end
        end
      end
      HS_QUIET: begin
        // (R8) strobe parked low before next start
        // select rises with strobe still high, so 4-wire release rides on it
        if (cnt_r == `ADCSR_CNT_W'(`ADCSR_QUIET_CYC)) begin
          strobe_nxt = 1'b0;
        end
        if (cntDone) begin
          rdData_nxt = data_r;
          valid_nxt = 1'b1;
          busy_nxt = 1'b0;
          state_nxt = HS_IDLE;
        end
      end
      default: begin
        state_nxt = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= HS_IDLE;
      mode_r <= ADCSR_M3W;
      cnt_r <= `ADCSR_CNT_W'(0);
      bitCnt_r <= 6'h00;
      data_r <= TotW'(0);
      rdData_r <= TotW'(0);
      sclk_r <= 1'b0;
      strobe_r <= 1'b0;
      din_r <= 1'b1;
      valid_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      bitCnt_r <= bitCnt_nxt;
      data_r <= data_nxt;
      rdData_r <= rdData_nxt;
      sclk_r <= sclk_nxt;
      strobe_r <= strobe_nxt;
      din_r <= din_nxt;
      valid_r <= valid_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign link.sclk = sclk_r;
  assign link.convStrobe = strobe_r;
  assign link.din = din_r;
  assign rdData = rdData_r;
  assign rdValid = valid_r;
  assign busy = busy_r;

endmodule

// [adcsr_link_sva.sv]
// checker of the link wires between the two design ends
// assumes one core_clk domain and the signals of adcsr_if
`timescale 1ns/1ns
`include "adcsr_map.svh"

module adcsr_link_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link
  input wire logic convStrobe,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic doutOeN,
  input wire logic doutWire
);
  localparam int CONV_CYC = `ADCSR_CONV_CYC;
  logic strobeDly_r, strobeDly_nxt;
  logic [11:0] convCnt_r, convCnt_nxt;
  // cycles since strobe rise; saturates so a long idle never wraps
  always_comb begin
    strobeDly_nxt = convStrobe;
    convCnt_nxt = (convCnt_r == 12'hFFF) ? convCnt_r : convCnt_r + 12'h001;
    if (convStrobe && !strobeDly_r) begin
      convCnt_nxt = 12'h001;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobeDly_r <= 1'b0;
      convCnt_r <= 12'h000;
    end else begin
      strobeDly_r <= strobeDly_nxt;
      convCnt_r <= convCnt_nxt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_released; ##[1:5] doutOeN; endsequence
  sequence s_strap_steady; $stable(din) && ($past(din, 2) == din); endsequence
  sequence s_clk_low; !sclk ##1 !sclk; endsequence
  property p_strobe_high; $rose(convStrobe) |-> convStrobe [*3]; endproperty
  property p_bit_hold;
    (sclk && $past(sclk, 4) && !doutOeN && !$past(doutOeN)) |-> $stable(dout) && $stable(doutWire);
  endproperty
  property p_enable_cause;
    $fell(doutOeN) |-> (!convStrobe || !din) && (!$past(convStrobe, 2) || !$past(din, 2));
  endproperty
  property p_release_strobe; $rose(convStrobe) |-> s_released; endproperty
  property p_release_din; ($rose(din) && convStrobe) |-> s_released; endproperty
  property p_select_gap; $rose(din) |-> din [*3]; endproperty
  property p_strobe_gap; $fell(convStrobe) |-> !convStrobe [*5]; endproperty
  property p_strap_setup; $rose(convStrobe) |-> s_strap_steady; endproperty
  property p_clk_quiet; $rose(convStrobe) |-> s_clk_low; endproperty
  property p_conv_wait; $rose(sclk) |-> convCnt_r >= CONV_CYC; endproperty
  a_strobe_high: assert property (p_strobe_high)
    else $error("strobe high pulse too short");
  a_bit_hold: assert property (p_bit_hold)
    else $error("data changed while shift clock high");
  a_enable_cause: assert property (p_enable_cause)
    else $error("output enabled without a select");
  a_release_strobe: assert property (p_release_strobe)
    else $error("output not released after strobe rise");
  a_release_din: assert property (p_release_din)
    else $error("output not released after select high");
  a_select_gap: assert property (p_select_gap)
    else $error("select high gap too short");
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("strobe low gap too short");
  a_strap_setup: assert property (p_strap_setup)
    else $error("mode level not steady at strobe rise");
  a_clk_quiet: assert property (p_clk_quiet)
    else $error("shift clock moving at strobe rise");
  a_conv_wait: assert property (p_conv_wait)
    else $error("read-out began before conversion end");
endmodule

// [tb_top.sv]
// self-checking bench: host end and converter end joined by one link
// assumes both ends keep the link timing by themselves
`timescale 1ns/1ns
`include "adcsr_map.svh"

module tb_top;
  import adcsr_pkg::*;
  logic core_clk, rst_n, clkEn, start, busy, rdValid, lowPower, chainMode;
  adcsr_mode_t mode;
  logic [15:0] sampleData;
  logic [31:0] rdData, shiftCap;
  logic [7:0] nFall;
  int n_errors, n_checks;
  adcsr_if lnk();
  adcsr_dev u_adcsr_dev (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .sampleData(sampleData), .lowPower(lowPower), .chainMode(chainMode), .link(lnk.dev));
  adcsr_host u_adcsr_host (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .start(start), .mode(mode), .busy(busy), .rdData(rdData), .rdValid(rdValid),
    .link(lnk.host));
  adcsr_link_sva u_adcsr_link_sva (.core_clk(core_clk), .rst_n(rst_n),
    .convStrobe(lnk.convStrobe), .sclk(lnk.sclk), .din(lnk.din), .dout(lnk.dout),
    .doutOeN(lnk.doutOeN), .doutWire(lnk.doutWire));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // wire monitors: bits as the host sees them, and clock falls per frame
  always @(posedge lnk.sclk) shiftCap = {shiftCap[30:0], lnk.doutWire};
  always @(negedge lnk.sclk) nFall = nFall + 8'h01;
  // chain: own result first, then the zeros the host line feeds upstream
  function automatic logic [31:0] exp_word(input adcsr_mode_t m, input logic [15:0] d);
    return (m == ADCSR_MCHAIN) ? {d, 16'h0000} : {16'h0000, d};
  endfunction
  function automatic logic [31:0] exp_falls(input adcsr_mode_t m);
    return (m == ADCSR_MCHAIN) ? 32'h20 : 32'h10;
  endfunction
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic run_frame(input adcsr_mode_t m, input logic [15:0] d);
    int k;
    sampleData = d;
    mode = m;
    shiftCap = 32'h0;
    nFall = 8'h00;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    repeat (100) @(posedge core_clk);
    #1;
    chk1(lowPower, 1'b0);
    chk1(lnk.doutOeN, 1'b1);
    chk1(chainMode, m == ADCSR_MCHAIN);
    // a frozen clock enable must stall both ends alike
    clkEn = 1'b0;
    repeat (1 + $urandom_range(7, 0)) @(posedge core_clk);
    #1 clkEn = 1'b1;
    chk1(lnk.convStrobe, 1'b1);
    chk1(busy, 1'b1);
    // a start while busy must leave no trace
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    k = 0;
    while (rdValid !== 1'b1 && k < 4000) begin
      @(posedge core_clk);
      #1 k++;
    end
    chk1(rdValid, 1'b1);
    chk1(busy, 1'b0);
    chk32(rdData, exp_word(m, d));
    chk32(shiftCap, exp_word(m, d));
    chk32({24'h0, nFall}, exp_falls(m));
    chk1(lowPower, 1'b1);
    if (m != ADCSR_MCHAIN) begin
      chk1(lnk.doutWire, 1'b1);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    start = 1'b0;
    mode = ADCSR_M3W;
    sampleData = 16'h0000;
    shiftCap = 32'h0;
    nFall = 8'h00;
    n_errors = 0;
    n_checks = 0;
    void'($urandom(32'h12F5029D));
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    // corner values in every mode, back to back
    run_frame(ADCSR_M3W, 16'hFFFF);
    run_frame(ADCSR_M4W, 16'h0000);
    run_frame(ADCSR_MCHAIN, 16'h8001);
    run_frame(ADCSR_M4W, 16'h7FFE);
    run_frame(ADCSR_M3W, 16'h8001);
    for (int i = 0; i < 4; i++) begin
      run_frame(adcsr_mode_t'($urandom_range(2, 0)), 16'($urandom));
    end
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end
endmodule
